// ==== swd_pkg.sv ====
// swd_pkg: constants and types shared by the system watchdog files.
// assumes a single system clock; the default interval is derived from DFLT_REF_CLK_HZ, not CLK_HZ.
package swd_pkg;

   ////////////////////////////////////////////////////////////////////////
   // widths
   localparam int unsigned CNT_W   = 16;
   localparam int unsigned PRESC_W = 14;

   ////////////////////////////////////////////////////////////////////////
   // prescaler factors, selected by one control bit
   localparam logic [PRESC_W-1:0] DIV_LOW_LAST  = 14'h00FF;  // 256 - 1
   localparam logic [PRESC_W-1:0] DIV_HIGH_LAST = 14'h3FFF;  // 16384 - 1
   localparam logic               DIV_SEL_LOW   = 1'h0;
   localparam logic               DIV_SEL_HIGH  = 1'h1;

   ////////////////////////////////////////////////////////////////////////
   // system clock of this block
   localparam int unsigned CLK_HZ = 50_000_000;

   ////////////////////////////////////////////////////////////////////////
   // default interval: 6.5 ms at a 10 MHz reference clock
   localparam int unsigned DFLT_INTERVAL_TENTH_MS = 65;
   localparam int unsigned DFLT_REF_CLK_HZ        = 10_000_000;
   localparam int unsigned DFLT_INTERVAL_CYC =
      DFLT_INTERVAL_TENTH_MS * (DFLT_REF_CLK_HZ / 10_000);
   localparam int unsigned DFLT_DIV = 256;
   // nearest whole number of ticks
   localparam int unsigned DFLT_TICKS =
      (DFLT_INTERVAL_CYC + DFLT_DIV / 2) / DFLT_DIV;
   localparam logic [CNT_W-1:0] RELOAD_RST =
      CNT_W'(32'd65536 - DFLT_TICKS);
   localparam logic DIV_SEL_RST = DIV_SEL_LOW;

   ////////////////////////////////////////////////////////////////////////
   // watchdog states
   typedef enum logic [2:0] {
      SWD_WATCH   = 3'b001,
      SWD_PREWARN = 3'b010,
      SWD_RESET   = 3'b100
   } swd_state_t;

endpackage

// ==== swd_tick_if.sv ====
// swd_tick_if: control and tick wires between watchdog core and prescaler.
// assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface swd_tick_if;
   logic clear;     // restart prescaler from zero
   logic enable;    // prescaler may count
   logic div_sel;   // active divider choice
   logic tick;      // one-cycle enable pulse

   modport ctrl  (output clear, output enable, output div_sel, input tick);
   modport presc (input clear, input enable, input div_sel, output tick);
endinterface

// ==== swd_prescaler.sv ====
// swd_prescaler: divides the system clock by 256 or 16384.
// assumes clear and enable come from the watchdog core in the same domain.
`timescale 1ns/1ps
module swd_prescaler
   import swd_pkg::*;
#(
   parameter int unsigned W = PRESC_W
)
(
   input  wire logic clock_in,   // system clock
   input  wire logic rst_n_in,   // async reset, active low
   swd_tick_if.presc tick_if     // control in, tick out
);

   logic [W-1:0] div_reg;
   logic [W-1:0] div_next;
   logic         tick_reg;
   logic         tick_next;
   logic [W-1:0] last;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      last      = (tick_if.div_sel == DIV_SEL_HIGH) ? W'(DIV_HIGH_LAST)
                                                    : W'(DIV_LOW_LAST);
      div_next  = div_reg;
      tick_next = 1'b0;
      if (tick_if.clear)
      begin
         div_next = '0;  // RL7
      end
      else if (tick_if.enable)
      begin
         if (div_reg >= last)
         begin
            div_next  = '0;
            tick_next = 1'b1;  // RL5
         end
         else
         begin
            div_next = div_reg + W'(1);
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         div_reg  <= '0;
         tick_reg <= 1'b0;
      end
      else
      begin
         div_reg  <= div_next;
         tick_reg <= tick_next;
      end
   end

   // registered tick: one cycle late, harmless at these divide ratios
   assign tick_if.tick = tick_reg;

endmodule

// ==== swd_watchdog.sv ====
// swd_watchdog: fail-safe 16-bit system watchdog with prescaler.
// assumes service and enable/disable strobes are one-cycle pulses
// synchronous to clock_in, issued by the instruction decoder.
`timescale 1ns/1ps

// Overview of operation
// RL1 - after reset the watchdog counts immediately, no software needed
// RL2 - disable strobe stops counting, enable strobe restarts, any time; here counting stays stopped once the reset request is raised
// RL3 - software must service before overflow to avoid prewarning
// RL4 - overflow raises prewarning pulse first, then a reset request
// RL5 - 16-bit counter ticking at system clock over 256 or 16384
// RL6 - counter is loaded from a software-programmable reload value
// RL7 - service reloads the counter and clears the prescaler; here a service is ignored once the prewarning phase has begun
// RL8 - reset defaults give a 6.5 ms interval at 10 MHz
// RL9 - counter counts up from reload; overflow is wrap from all ones
// RL10 - divider choice bit takes effect at the next service or reload
module swd_watchdog
   import swd_pkg::*;
#(
   parameter int unsigned CW = CNT_W
)
(
   input  wire logic          clock_in,         // system clock
   input  wire logic          rst_n_in,         // async reset, active low
   input  wire logic          service_in,       // service strobe
   input  wire logic          watchdog_disable_instr_in, // stop strobe
   input  wire logic          watchdog_enable_instr_in,  // start strobe
   input  wire logic          reload_wr_in,     // reload value write
   input  wire logic [CW-1:0] reload_data_in,   // new reload value
   input  wire logic          div_sel_wr_in,    // divider choice write
   input  wire logic          div_sel_in,       // 1: 16384, 0: 256
   output logic [CW-1:0]      count_out,        // counter value
   output logic [CW-1:0]      interval_reload_value_out, // reload value
   output logic               div_sel_out,      // stored divider choice
   output logic               running_out,      // watchdog enabled
   output logic               prewarn_irq_out,  // prewarning pulse
   output logic               prewarn_out,      // in prewarning phase
   output logic               reset_req_out     // reset request level
);

   ////////////////////////////////////////////////////////////////////////
   // state
   swd_state_t    state_reg;
   swd_state_t    state_next;
   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;
   logic [CW-1:0] interval_reload_value_reg;
   logic [CW-1:0] interval_reload_value_next;
   logic          div_sel_reg;
   logic          div_sel_next;
   logic          div_act_reg;
   logic          div_act_next;
   logic          enabled_reg;
   logic          enabled_next;
   logic          irq_reg;
   logic          irq_next;
   logic          clr_reg;
   logic          clr_next;

   logic          overflow;
   logic          do_service;
   logic          count_tick;

   swd_tick_if tick_if ();

   swd_prescaler #(
      .W (PRESC_W)
   ) u_presc (
      .clock_in (clock_in),
      .rst_n_in (rst_n_in),
      .tick_if  (tick_if.presc)
   );

   assign tick_if.clear   = clr_reg;
   assign tick_if.enable  = enabled_reg && (state_reg != SWD_RESET);
   assign tick_if.div_sel = div_act_reg;

   ////////////////////////////////////////////////////////////////////////
   // software settings: reload value, divider choice, enable
   always_comb
   begin
      interval_reload_value_next = interval_reload_value_reg;
      div_sel_next               = div_sel_reg;
      enabled_next               = enabled_reg;

      if (reload_wr_in)
      begin
         interval_reload_value_next = reload_data_in;  // RL6
      end
      if (div_sel_wr_in)
      begin
         div_sel_next = div_sel_in;  // RL10
      end

      // enable wins a tie: the fail-safe direction
      if (watchdog_enable_instr_in)
      begin
         enabled_next = 1'b1;  // RL2
      end
      else if (watchdog_disable_instr_in)
      begin
         enabled_next = 1'b0;  // RL2
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         interval_reload_value_reg <= RELOAD_RST;  // RL8
         div_sel_reg               <= DIV_SEL_RST;  // RL8
         enabled_reg               <= 1'b1;  // RL1
      end
      else
      begin
         interval_reload_value_reg <= interval_reload_value_next;
         div_sel_reg               <= div_sel_next;
         enabled_reg               <= enabled_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counter and prescaler control
   always_comb
   begin
      // a tick right after a service is dropped while the clear lands
      count_tick = tick_if.tick && tick_if.enable && !clr_reg;  // RL5
      overflow   = count_tick && (count_reg == {CW{1'b1}});  // RL9
      // once prewarned, a service can no longer avert the reset
      do_service = service_in && (state_reg == SWD_WATCH);

      count_next   = count_reg;
      div_act_next = div_act_reg;
      clr_next     = 1'b0;

      if (do_service)
      begin
         count_next   = interval_reload_value_reg;  // RL7
         div_act_next = div_sel_reg;  // RL10
         clr_next     = 1'b1;  // RL7
      end
      else if (count_tick)
      begin
         if (overflow)
         begin
            // second interval runs before the reset request
            count_next   = interval_reload_value_reg;  // RL6
            div_act_next = div_sel_reg;  // RL10
         end
         else
         begin
            count_next = count_reg + CW'(1);  // RL9
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         count_reg   <= RELOAD_RST;  // RL8
         div_act_reg <= DIV_SEL_RST;
         clr_reg     <= 1'b0;
      end
      else
      begin
         count_reg   <= count_next;
         div_act_reg <= div_act_next;
         clr_reg     <= clr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // warning and reset request sequence
   always_comb
   begin
      state_next = state_reg;
      irq_next   = 1'b0;

      case (state_reg)
         SWD_WATCH:
         begin
            if (overflow && !do_service)
            begin
               state_next = SWD_PREWARN;
               irq_next   = 1'b1;  // RL4
            end
         end
         SWD_PREWARN:
         begin
            if (overflow)
            begin
               state_next = SWD_RESET;  // RL4
            end
         end
         SWD_RESET:
         begin
            state_next = SWD_RESET;
         end
         default:
         begin
            state_next = SWD_RESET;
         end
      endcase
   end

   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_reg <= SWD_WATCH;
         irq_reg   <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         irq_reg   <= irq_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, all straight from flip-flops
   assign count_out                 = count_reg;
   assign interval_reload_value_out = interval_reload_value_reg;
   assign div_sel_out               = div_sel_reg;
   assign running_out               = enabled_reg;
   assign prewarn_irq_out           = irq_reg;
   assign prewarn_out               = state_reg[1];
   assign reset_req_out             = state_reg[2];

endmodule

// ==== swd_watchdog_monitor.sv ====
// swd_watchdog_monitor: port-level checks of the system watchdog.
// assumes it is bound to swd_watchdog and sees only its ports.
`timescale 1ns/1ps
module swd_watchdog_monitor
   import swd_pkg::*;
(
   input wire logic             clock_in,                  // clock
   input wire logic             rst_n_in,                  // reset
   input wire logic             service_in,                // service
   input wire logic             watchdog_disable_instr_in, // stop
   input wire logic             watchdog_enable_instr_in,  // start
   input wire logic [CNT_W-1:0] count_out,                 // counter
   input wire logic [CNT_W-1:0] interval_reload_value_out, // reload
   input wire logic             running_out,               // enabled
   input wire logic             prewarn_irq_out,           // warn pulse
   input wire logic             prewarn_out,               // warn phase
   input wire logic             reset_req_out              // request
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);
   // service is refused once the warning phase has begun
   wire live = !prewarn_out && !reset_req_out;
   sequence warn_seq;
      prewarn_irq_out ##1 !prewarn_irq_out;
   endsequence
   chk_svc_reload: assert property (service_in && live |=>
      count_out == $past(interval_reload_value_out))
      else $error("service did not reload");
   chk_stop_hold: assert property (!running_out && !$past(running_out)
      && !watchdog_enable_instr_in && !service_in |=> $stable(count_out))
      else $error("stopped count moved");
   chk_dis_stop: assert property (watchdog_disable_instr_in &&
      !watchdog_enable_instr_in |=> !running_out)
      else $error("stop ignored");
   chk_en_start: assert property (watchdog_enable_instr_in
      |=> running_out) else $error("start ignored");
   chk_warn_pulse: assert property ($rose(prewarn_out) |-> warn_seq)
      else $error("bad warning pulse");
   chk_warn_first: assert property ($rose(reset_req_out) |->
      $past(prewarn_out) && !prewarn_out) else $error("no warning first");
   chk_req_sticky: assert property (reset_req_out |=>
      reset_req_out && $stable(count_out)) else $error("request dropped");
   chk_wrap_warn: assert property ($rose(prewarn_irq_out) |->
      $past(count_out) == 16'hFFFF) else $error("warning without wrap");
endmodule
bind swd_watchdog swd_watchdog_monitor i_mon (.*);

// ==== swd_core_model.sv ====
// swd_core_model: core issuing watchdog instructions as strobes.
// assumes strobes are launched at rising edges, one cycle each.
`timescale 1ns/1ps
module swd_core_model
   import swd_pkg::*;
(
   input  wire logic        clock_in, // system clock
   output logic [4:0]       stb_out,  // service,stop,start,reload,div
   output logic [CNT_W-1:0] val_out   // reload value, bit 0 divider
);
   initial
   begin
      stb_out = 5'h00;
      val_out = 16'h0000;
   end
   // code 0 service, 1 stop, 2 start, 3 reload write, 4 divider write
   task automatic issue(input int code, input logic [CNT_W-1:0] val);
      @(posedge clock_in);
      stb_out <= 5'h01 << code;
      val_out <= val;
      @(posedge clock_in);
      stb_out <= 5'h00;
      // data no longer valid once the strobe is gone
      val_out <= ~val;
   endtask
endmodule

// ==== tb_top.sv ====
// tb_top: self-checking bench for the system watchdog.
// assumes swd_core_model drives every strobe of the design.
`timescale 1ns/1ps
module tb_top;
   import swd_pkg::*;
   logic             clock_in = 1'b0;
   logic             rst_n_in = 1'b0;
   logic [4:0]       stb;
   logic             dso, run, irq, pw, rq;
   logic [CNT_W-1:0] val, cnt, rel, c;
   int               err_count = 0;
   int               comparisons = 0;
   int               seed = 15914;
   int               n;
   initial
   begin
      forever #10 clock_in = ~clock_in;
   end
   swd_core_model i_swd_core_model (.clock_in(clock_in), .stb_out(stb),
      .val_out(val));
   swd_watchdog i_swd_watchdog (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .service_in(stb[0]), .watchdog_disable_instr_in(stb[1]),
      .watchdog_enable_instr_in(stb[2]), .reload_wr_in(stb[3]),
      .reload_data_in(val), .div_sel_wr_in(stb[4]), .div_sel_in(val[0]),
      .count_out(cnt), .interval_reload_value_out(rel), .div_sel_out(dso),
      .running_out(run), .prewarn_irq_out(irq), .prewarn_out(pw),
      .reset_req_out(rq));
   ////////////////////////////////////////////////////////////////////
   function automatic logic [CNT_W-1:0] dflt_reload();
      // 6.5 ms at 10 MHz, nearest whole tick of 256
      return CNT_W'(65536 - (65000 + 128) / 256);
   endfunction
   function automatic logic [CNT_W-1:0] step(input logic div);
      return div ? 16'h4000 : 16'h0100;
   endfunction
   task automatic check(input string what, input logic [CNT_W-1:0] exp,
                        input logic [CNT_W-1:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // cycles between two count changes, sampled off the edge
   task automatic step_len();
      @(negedge clock_in);
      for (int k = 0; k < 2; k++)
      begin
         c = cnt;
         n = 0;
         while (cnt === c && n < 40000)
         begin
            @(negedge clock_in);
            n++;
         end
      end
   endtask
   task automatic wait_flag(input bit req);
      n = 0;
      while ((req ? rq : irq) !== 1'b1 && n < 2000)
      begin
         @(negedge clock_in);
         n++;
      end
   endtask
   task automatic do_reset();
      @(posedge clock_in);
      rst_n_in <= 1'b0;
      repeat (10) @(posedge clock_in);
      rst_n_in <= 1'b1;
      @(negedge clock_in);
      check("count", dflt_reload(), cnt);
      check("reload", dflt_reload(), rel);
      check("div_sel", 16'h0000, 16'(dso));
      check("running", 16'h0001, 16'(run));
      check("request", 16'h0000, 16'(rq));
   endtask
   task automatic give_verdict();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      #1000000;
      err_count++;
      give_verdict();
   end
   initial
   begin
      do_reset();
      step_len();
      check("step", step(1'b0), 16'(n));
      i_swd_core_model.issue(4, 16'h0001);
      @(negedge clock_in);
      check("div_sel", 16'h0001, 16'(dso));
      step_len();
      check("step_old", step(1'b0), 16'(n));
      i_swd_core_model.issue(0, 16'h0000);
      step_len();
      check("step_new", step(1'b1), 16'(n));
      i_swd_core_model.issue(4, 16'h0000);
      @(negedge clock_in);
      check("div_sel", 16'h0000, 16'(dso));
      for (int i = 0; i < 6; i++)
      begin
         c = CNT_W'($random(seed));
         i_swd_core_model.issue(3, c);
         i_swd_core_model.issue(0, 16'h0000);
         @(negedge clock_in);
         check("reload", c, rel);
         check("count", c, cnt);
      end
      i_swd_core_model.issue(1, 16'h0000);
      @(negedge clock_in);
      check("running", 16'h0000, 16'(run));
      c = cnt;
      repeat (600) @(negedge clock_in);
      check("held", c, cnt);
      i_swd_core_model.issue(2, 16'h0000);
      step_len();
      check("step_run", step(1'b0), 16'(n));
      i_swd_core_model.issue(3, 16'hFFFE);
      i_swd_core_model.issue(0, 16'h0000);
      wait_flag(1'b0);
      check("irq", 16'h0001, 16'(irq));
      check("warn", 16'h0001, 16'(pw));
      check("wrap", 16'hFFFE, cnt);
      // a late service must not rescue the system
      i_swd_core_model.issue(0, 16'h0000);
      wait_flag(1'b1);
      check("request", 16'h0001, 16'(rq));
      check("warn_end", 16'h0000, 16'(pw));
      do_reset();
      give_verdict();
   end
endmodule
